// ==== verilog/charger_status_registers.v ====
// Charger status register bank, read-only except the writable interrupt mask and write-one-to-clear flags, with event interrupt
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "charger_status_defs.vh"
module charger_status_registers #(
	parameter ADDR_W = `ADDR_W,
	parameter DATA_W = `DATA_W
) (
	input wire sys_clk,
	input wire resetn,
	input wire clk_en,
	input wire [ADDR_W-1:0] bus_addr,
	input wire [DATA_W-1:0] bus_wdata,
	input wire bus_write,
	input wire bus_read,
	output reg [DATA_W-1:0] bus_rdata,
	output wire irq,
	input wire [2:0] charge_phase,
	input wire [3:0] input_source_type,
	input wire port_detect_done,
	input wire [1:0] current_optimiser_state,
	input wire thermal_regulation_flag,
	input wire data_line_detect_active,
	input wire battery_present,
	input wire input_switch_pair2_fitted,
	input wire input_switch_pair1_fitted,
	input wire adc_done,
	input wire oneshot_mode,
	input wire forward_mode,
	input wire min_system_regulation_flag,
	input wire fast_charge_timer_expired,
	input wire trickle_timer_expired,
	input wire precharge_timer_expired
);
	reg [7:0] phase_source_reg;
	reg [7:0] opt_thermal_reg;
	reg [7:0] switch_timer_reg;
	reg [7:0] irq_mask_reg;
	reg [7:0] phase_source_next;
	reg [7:0] opt_thermal_next;
	reg [7:0] switch_timer_next;
	reg [7:0] rdata_next;
	reg [2:0] phase_code;
	reg [3:0] source_code;
	reg [1:0] opt_code;
	wire [7:0] flag_bits;
	wire [7:0] irq_terms;
	wire [7:0] event_levels;
	wire [7:0] clear_bits;

	// Filter incoming codes so reserved values never appear
	always @* begin
		phase_code = charge_phase;
		if (charge_phase == `PHASE_RESERVED)
			phase_code = 3'h0;
		source_code = input_source_type;
		if (input_source_type == `SOURCE_GAP_LO || input_source_type == `SOURCE_GAP_HI ||
			input_source_type > `SOURCE_LAST)
			source_code = 4'h0;
		opt_code = current_optimiser_state;
		if (current_optimiser_state == `OPT_RESERVED)
			opt_code = 2'h0;
	end

	// Assemble the next value of each status register
	always @* begin
		phase_source_next = `STATUS_RESET;
		phase_source_next[`PHASE_HI:`PHASE_LO] = phase_code;
		phase_source_next[`SOURCE_HI:`SOURCE_LO] = source_code;
		phase_source_next[`PORT_DONE_BIT] = port_detect_done;
		opt_thermal_next = `STATUS_RESET;
		opt_thermal_next[`OPT_HI:`OPT_LO] = opt_code;
		opt_thermal_next[`THERMAL_BIT] = thermal_regulation_flag;
		opt_thermal_next[`DATA_LINE_BIT] = data_line_detect_active;
		opt_thermal_next[`BATT_PRESENT_BIT] = battery_present;
		switch_timer_next = `STATUS_RESET;
		switch_timer_next[`PAIR2_BIT] = input_switch_pair2_fitted;
		switch_timer_next[`PAIR1_BIT] = input_switch_pair1_fitted;
		switch_timer_next[`ADC_DONE_BIT] = adc_done & oneshot_mode;
		switch_timer_next[`MIN_SYS_BIT] = min_system_regulation_flag & forward_mode;
		switch_timer_next[`FAST_TMR_BIT] = fast_charge_timer_expired;
		switch_timer_next[`TRICKLE_TMR_BIT] = trickle_timer_expired;
		switch_timer_next[`PRE_TMR_BIT] = precharge_timer_expired;
	end

	// Status registers follow the hardware; bus writes never touch them
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			phase_source_reg <= `STATUS_RESET;
			opt_thermal_reg <= `STATUS_RESET;
			switch_timer_reg <= `STATUS_RESET;
		end else if (clk_en) begin
			phase_source_reg <= phase_source_next;
			opt_thermal_reg <= opt_thermal_next;
			switch_timer_reg <= switch_timer_next;
		end
	end

	// Interrupt mask register, the only location that stores written data (status writes only clear flags)
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			irq_mask_reg <= `IRQ_RESET;
		else if (clk_en && bus_write && bus_addr == `OFF_IRQ_MASK)
			irq_mask_reg <= bus_wdata;
	end

	// Events that raise sticky flags
	assign event_levels[`EV_PORT_DONE] = phase_source_reg[`PORT_DONE_BIT];
	assign event_levels[`EV_ADC_DONE] = switch_timer_reg[`ADC_DONE_BIT];
	assign event_levels[`EV_FAST_TMR] = switch_timer_reg[`FAST_TMR_BIT];
	assign event_levels[`EV_TRICKLE_TMR] = switch_timer_reg[`TRICKLE_TMR_BIT];
	assign event_levels[`EV_PRE_TMR] = switch_timer_reg[`PRE_TMR_BIT];
	assign event_levels[`EV_THERMAL] = opt_thermal_reg[`THERMAL_BIT];
	assign event_levels[`EV_MIN_SYS] = switch_timer_reg[`MIN_SYS_BIT];
	assign event_levels[`EV_PHASE] = (phase_source_reg[`PHASE_HI:`PHASE_LO] == `PHASE_DONE);

	// Write one to clear on the interrupt status register
	assign clear_bits = (bus_write && bus_addr == `OFF_IRQ_STATUS) ? bus_wdata : 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_EVENTS; gi = gi + 1) begin : g_flag
			status_flag_cell u_flag (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.clk_en(clk_en),
				.level_in(event_levels[gi]),
				.clear(clear_bits[gi]),
				.mask_bit(irq_mask_reg[gi]),
				.flag_reg(flag_bits[gi]),
				.irq_term(irq_terms[gi])
			);
		end
	endgenerate

	// Level interrupt while any unmasked flag is set
	assign irq = |irq_terms;

	// Read decode; unmapped addresses read zero
	always @* begin
		case (bus_addr)
			`OFF_PHASE_SOURCE: rdata_next = phase_source_reg;
			`OFF_OPT_THERMAL: rdata_next = opt_thermal_reg;
			`OFF_SWITCH_TIMER: rdata_next = switch_timer_reg;
			`OFF_IRQ_STATUS: rdata_next = flag_bits;
			`OFF_IRQ_MASK: rdata_next = irq_mask_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data registered, valid the cycle after the read strobe
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			bus_rdata <= 8'h00;
		else if (clk_en && bus_read)
			bus_rdata <= rdata_next;
	end
endmodule // charger_status_registers

// ==== verilog/charger_status_defs.vh ====
// Constants for the charger status register bank
`ifndef CHARGER_STATUS_DEFS_VH
`define CHARGER_STATUS_DEFS_VH

`define ADDR_W 8
`define DATA_W 8
// Register offsets
`define OFF_PHASE_SOURCE 8'h1c
`define OFF_OPT_THERMAL 8'h1d
`define OFF_SWITCH_TIMER 8'h1e
`define OFF_IRQ_STATUS 8'h30
`define OFF_IRQ_MASK 8'h31
// Field positions
`define PHASE_HI 7
`define PHASE_LO 5
`define SOURCE_HI 4
`define SOURCE_LO 1
`define PORT_DONE_BIT 0
`define OPT_HI 7
`define OPT_LO 6
`define THERMAL_BIT 2
`define DATA_LINE_BIT 1
`define BATT_PRESENT_BIT 0
`define PAIR2_BIT 7
`define PAIR1_BIT 6
`define ADC_DONE_BIT 5
`define MIN_SYS_BIT 4
`define FAST_TMR_BIT 3
`define TRICKLE_TMR_BIT 2
`define PRE_TMR_BIT 1
// Code limits
`define PHASE_RESERVED 3'h5
`define SOURCE_GAP_LO 4'h9
`define SOURCE_GAP_HI 4'ha
`define SOURCE_LAST 4'hc
`define OPT_RESERVED 2'h3
`define PHASE_DONE 3'h7
// Reset values, event count and event bit indices
`define STATUS_RESET 8'h00
`define IRQ_RESET 8'h00
`define IRQ_EVENTS 8
`define EV_PORT_DONE 0
`define EV_ADC_DONE 1
`define EV_FAST_TMR 2
`define EV_TRICKLE_TMR 3
`define EV_PRE_TMR 4
`define EV_THERMAL 5
`define EV_MIN_SYS 6
`define EV_PHASE 7

`endif

// ==== verilog/status_flag_cell.v ====
// One sticky event flag with edge detect, mask and write-one-to-clear
`timescale 1ns/1ns
module status_flag_cell (
	input wire sys_clk,
	input wire resetn,
	input wire clk_en,
	input wire level_in,
	input wire clear,
	input wire mask_bit,
	output reg flag_reg,
	output wire irq_term
);
	reg last_reg;

	// Rising edge of the level sets the flag; a set beats a clear
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			last_reg <= 1'b0;
			flag_reg <= 1'b0;
		end else if (clk_en) begin
			last_reg <= level_in;
			if (level_in && !last_reg)
				flag_reg <= 1'b1;
			else if (clear)
				flag_reg <= 1'b0;
		end
	end

	// Unmasked contribution to the interrupt
	assign irq_term = flag_reg & mask_bit;
endmodule // status_flag_cell

// ==== tb/status_regs_asserts.sv ====
// Port assertions for the charger status register bank
`timescale 1ns/1ns
module status_regs_asserts (
	input wire sys_clk,
	input wire resetn,
	input wire clk_en,
	input wire [7:0] bus_addr,
	input wire bus_read,
	input wire [7:0] bus_rdata,
	input wire [2:0] charge_phase,
	input wire [3:0] input_source_type,
	input wire [1:0] current_optimiser_state,
	input wire input_switch_pair1_fitted,
	input wire oneshot_mode,
	input wire forward_mode
);
	reg en_q;
	wire rd;
	// Status was captured on the previous edge only if enabled then
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			en_q <= 1'b0;
		else
			en_q <= clk_en;
	end
	assign rd = bus_read && clk_en && en_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	phase_pass_a: assert property (rd && bus_addr == 8'h1c && $past(charge_phase) != 3'h5
		|=> bus_rdata[7:5] == $past(charge_phase, 2)) else $error("phase field wrong");
	phase_resv_a: assert property (rd && bus_addr == 8'h1c && $past(charge_phase) == 3'h5
		|=> bus_rdata[7:5] == 3'h0) else $error("reserved phase shown");
	source_pass_a: assert property (rd && bus_addr == 8'h1c && $past(input_source_type) < 4'h9
		|=> bus_rdata[4:1] == $past(input_source_type, 2)) else $error("source field wrong");
	source_resv_a: assert property (rd && bus_addr == 8'h1c
		|=> !(bus_rdata[4:1] inside {4'h9, 4'ha, 4'hd, 4'he, 4'hf})) else $error("bad source");
	opt_field_a: assert property (rd && bus_addr == 8'h1d && $past(current_optimiser_state) != 2'h3
		|=> bus_rdata[7:6] == $past(current_optimiser_state, 2) && bus_rdata[5:3] == 3'h0)
		else $error("optimiser field wrong");
	adc_gate_a: assert property (rd && bus_addr == 8'h1e && !$past(oneshot_mode)
		|=> !bus_rdata[5]) else $error("conversion flag outside one-shot");
	min_sys_gate_a: assert property (rd && bus_addr == 8'h1e && !$past(forward_mode)
		|=> !bus_rdata[4]) else $error("min system flag outside forward");
	pair_one_a: assert property (rd && bus_addr == 8'h1e
		|=> bus_rdata[6] == $past(input_switch_pair1_fitted, 2) && !bus_rdata[0])
		else $error("switch pair bit wrong");
endmodule // status_regs_asserts

// ==== tb/testbench.sv ====
// Self-checking bench for the charger status register bank
`timescale 1ns/1ns
module testbench;
	reg sys_clk = 1'b0;
	reg resetn = 1'b0;
	reg [7:0] bus_addr = 8'h00;
	reg [7:0] bus_wdata = 8'h00;
	reg bus_write = 1'b0;
	reg bus_read = 1'b0;
	reg clk_en = 1'b1;
	reg [23:0] s = 24'h000000;
	reg [7:0] d;
	reg [7:0] a;
	wire [7:0] bus_rdata;
	wire irq;
	integer miscompares = 0;
	integer checked = 0;
	integer i;
	// Clock
	always #5 sys_clk = ~sys_clk;
	// Status inputs laid out as their register bits
	charger_status_registers u_dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
		.bus_rdata(bus_rdata), .irq(irq), .charge_phase(s[7:5]), .input_source_type(s[4:1]),
		.port_detect_done(s[0]), .current_optimiser_state(s[15:14]),
		.thermal_regulation_flag(s[10]), .data_line_detect_active(s[9]), .battery_present(s[8]),
		.input_switch_pair2_fitted(s[23]), .input_switch_pair1_fitted(s[22]), .adc_done(s[21]),
		.oneshot_mode(s[13]), .forward_mode(s[12]), .min_system_regulation_flag(s[20]),
		.fast_charge_timer_expired(s[19]), .trickle_timer_expired(s[18]),
		.precharge_timer_expired(s[17]));
	task chk(input [7:0] got, input [7:0] exp_v);
		begin
			checked = checked + 1;
			if (got !== exp_v) begin
				miscompares = miscompares + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp_v);
			end
		end
	endtask
	// Interrupt level compare
	task chk_irq(input exp_v);
		begin
			checked = checked + 1;
			if (irq !== exp_v) begin
				miscompares = miscompares + 1;
				$display("Error at %0t: irq %h expected %h", $time, irq, exp_v);
			end
		end
	endtask
	task wr(input [7:0] ad, input [7:0] v);
		begin
			bus_addr <= ad;
			bus_wdata <= v;
			bus_write <= 1'b1;
			@(posedge sys_clk);
			bus_write <= 1'b0;
		end
	endtask
	task rd(input [7:0] ad);
		begin
			bus_addr <= ad;
			bus_read <= 1'b1;
			@(posedge sys_clk);
			bus_read <= 1'b0;
			#1 d = bus_rdata;
			@(posedge sys_clk);
		end
	endtask
	function [7:0] want(input [7:0] ad);
		begin
			want = 8'h00;
			if (ad == 8'h1c)
				want = {(s[7:5] == 3'h5) ? 3'h0 : s[7:5],
					(s[4:1] > 4'hc || s[4:1] == 4'h9 || s[4:1] == 4'ha) ? 4'h0 : s[4:1], s[0]};
			if (ad == 8'h1d)
				want = {(s[15:14] == 2'h3) ? 2'h0 : s[15:14], 3'h0, s[10:8]};
			if (ad == 8'h1e)
				want = {s[23:22], s[21] & s[13], s[20] & s[12], s[19:17], 1'b0};
		end
	endfunction
	task t_reset;
		for (a = 8'h1c; a < 8'h20; a = a + 8'h01) begin
			rd(a);
			chk(d, 8'h00);
		end
	endtask
	task t_irq;
		begin
			wr(8'h31, 8'h01);
			s <= 24'h000001;
			repeat (3) @(posedge sys_clk);
			#1 chk_irq(1'b1);
			@(posedge sys_clk);
			wr(8'h30, 8'h01);
			#1 chk_irq(1'b0);
			@(posedge sys_clk);
			s <= 24'h000401;
			repeat (3) @(posedge sys_clk);
			rd(8'h30);
			chk(d, 8'h20);
			chk_irq(1'b0);
		end
	endtask
	// Clock enable low freezes status, mask and read data
	task t_freeze;
		begin
			s <= 24'h000002;
			repeat (2) @(posedge sys_clk);
			rd(8'h1c);
			chk(d, 8'h02);
			clk_en <= 1'b0;
			s <= 24'h000004;
			wr(8'h31, 8'h00);
			rd(8'h1c);
			chk(d, 8'h02);
			clk_en <= 1'b1;
			rd(8'h31);
			chk(d, 8'h01);
			rd(8'h1c);
			chk(d, 8'h04);
		end
	endtask
	task t_walk;
		for (i = 0; i < 256; i = i + 1) begin
			s <= {i[7:0], i[3:0], i[7:4], i[7:0]};
			wr(8'h1c + {6'h00, i[1:0]}, 8'hff);
			@(posedge sys_clk);
			for (a = 8'h1c; a < 8'h20; a = a + 8'h01) begin
				rd(a);
				chk(d, want(a));
			end
		end
	endtask
	task stop_test;
		begin
			if (miscompares == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_irq;
		t_walk;
		t_freeze;
		stop_test;
	end
	// Watchdog
	initial begin
		#200000;
		miscompares = miscompares + 1;
		stop_test;
	end
endmodule // testbench
bind charger_status_registers status_regs_asserts u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.clk_en(clk_en), .bus_addr(bus_addr), .bus_read(bus_read), .bus_rdata(bus_rdata),
	.charge_phase(charge_phase), .input_source_type(input_source_type),
	.current_optimiser_state(current_optimiser_state),
	.input_switch_pair1_fitted(input_switch_pair1_fitted), .oneshot_mode(oneshot_mode),
	.forward_mode(forward_mode));
